// >>> logic/spc_cfg.svh
// constants of the self-programming controller: offsets, fields, windows
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------------------------------------
// apb register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define SPC_OFS_CTRL 8'h00
`define SPC_OFS_STATUS 8'h04
`define SPC_OFS_LOCK 8'h08
`define SPC_OFS_FUSE 8'h0C
`define SPC_OFS_W 8

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SPC_CTRL_ARM 0
`define SPC_CTRL_ERASE 1
`define SPC_CTRL_WRITE 2
`define SPC_CTRL_LFSEL 3
`define SPC_CTRL_RWW 4
`define SPC_CTRL_BUSY 7
`define SPC_CTRL_CMD_W 5

// ----------------------------------------------------------------------
// the only accepted patterns of the low five control bits
// ----------------------------------------------------------------------
`define SPC_PAT_RWW 5'h11
`define SPC_PAT_LFSEL 5'h09
`define SPC_PAT_WRITE 5'h05
`define SPC_PAT_ERASE 5'h03
`define SPC_PAT_FILL 5'h01

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SPC_STAT_OP_BUSY 0
`define SPC_STAT_EE_BUSY 1
`define SPC_STAT_REFUSED 2

// ----------------------------------------------------------------------
// lock byte layout and reset
// ----------------------------------------------------------------------
`define SPC_LOCK_APP_WP 2
`define SPC_LOCK_BOOT_WP 4
`define SPC_LOCK_SW_MASK 8'h3C
`define SPC_LOCK_RESET 8'h00

// ----------------------------------------------------------------------
// arm windows, in clock cycles after the arming write
// ----------------------------------------------------------------------
`define SPC_CNT_W 3
`define SPC_STORE_WIN 3'h4
`define SPC_LOAD_WIN 3'h3

// ----------------------------------------------------------------------
// pointer values that select a lock or fuse byte
// ----------------------------------------------------------------------
`define SPC_PTR_FUSE_LOW 16'h0000
`define SPC_PTR_LOCK 16'h0001
`define SPC_PTR_EXT_FUSE 16'h0002
`define SPC_PTR_FUSE_HIGH 16'h0003

// ----------------------------------------------------------------------
// page geometry: 64 words per page, 16-bit pointer to bytes
// ----------------------------------------------------------------------
`define SPC_WORD_W 16
`define SPC_BUF_AW 6
`define SPC_PAGE_W 9
`define SPC_PAGE_LSB 7
`define SPC_BOOT_START 9'h1C0

`endif

// >>> logic/spc_pkg.sv
// types shared by the self-programming controller
package spc_pkg;

  // ----------------------------------------------------------------------
  // command latched by an arming write
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    spc_cmd_none,
    spc_cmd_fill,
    spc_cmd_erase,
    spc_cmd_write,
    spc_cmd_lock,
    spc_cmd_rww
  } spc_cmd_e;

  // ----------------------------------------------------------------------
  // apb slave answer
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } spc_apb_s;

  // ----------------------------------------------------------------------
  // request towards the flash array
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic is_write;
    logic [8:0] page;
  } spc_flash_s;

  // ----------------------------------------------------------------------
  // page buffer write port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [15:0] data;
  } spc_buf_s;

  // ----------------------------------------------------------------------
  // all state of the controller
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic arm;
    spc_cmd_e cmd;
    logic [2:0] cnt;
    logic op_busy;
    logic refused;
    logic [7:0] lock;
    spc_apb_s apb;
    logic ld_valid;
    logic [7:0] ld_data;
    logic store_done;
    logic rww_pulse;
    spc_flash_s flash;
    spc_buf_s buf_wr;
  } spc_state_s;

endpackage : spc_pkg

// >>> logic/spc_page_buf.sv
// temporary page buffer: one write port, one registered read port
`timescale 1ns/1ns
module spc_page_buf #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // drain side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // array has no reset: contents are undefined until the page is filled
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : spc_page_buf

// >>> logic/spc_top.sv
// self-programming controller: arming, page buffer, flash ops, fuse reads
`timescale 1ns/1ns
`include "spc_cfg.svh"

// Overview of operation
// - an arming write opens the store instruction for four cycles only
// - arming with a command bit makes the next store run that command
// - arming alone makes the next store write the word pair to the buffer
// - pointer bit zero is ignored when addressing the page buffer
// - arm clears after a store completes or four idle cycles pass
// - arm stays set while a page erase or page write runs
// - control writes outside the five legal low patterns do nothing but flag refused during an eeprom write
// - eeprom write in progress blocks all software flash programming
// - eeprom write in progress blocks software lock and fuse reads; only loads are blocked, apb lock and fuse register reads are not
// - pointer one with lock access armed, load within three returns lock
// - lock access clears after read, three idle load or four store cycles
// - once lock access clears, loads read program memory again
// - pointer zero with lock access armed returns the fuse low byte
// - pointer three with lock access armed returns the fuse high byte
// - pointer two with lock access armed returns the extended fuse byte
// - two boot lock sets protect whole flash, boot, application or none
// - boot locks are set by software or programmer, cleared by chip erase
// - general write lock does not stop programming by store instruction
// - general read/write lock does not stop loads or stores
module spc_top #(
  parameter logic [8:0] BOOT_START_PAGE = `SPC_BOOT_START
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor core
  input wire logic program_store_instruction,
  input wire logic program_load_instruction,
  input wire logic [15:0] pointer,
  input wire logic [15:0] data_word_pair,
  output logic store_done,
  output logic lock_fuse_load_valid,
  output logic [7:0] lock_fuse_load_data,
  // eeprom, fuses and external programmer
  input wire logic eeprom_program_busy,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] extended_fuse_byte,
  input wire logic chip_erase,
  input wire logic ext_lock_set,
  input wire logic [7:0] ext_lock_data,
  // flash array
  input wire logic flash_done,
  input wire logic [5:0] flash_buf_addr,
  output logic [15:0] flash_buf_data,
  output logic flash_req,
  output logic flash_is_write,
  output logic [8:0] flash_page,
  output logic rww_section_reenable
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  spc_pkg::spc_state_s s;
  spc_pkg::spc_state_s next_s;

  logic acc;
  logic setup;
  logic [4:0] wcmd;
  logic [`SPC_PAGE_W-1:0] page;
  logic protected_page;
  logic [7:0] rd_ctrl;
  // decoded views of requests and registers
  logic [7:0] rd_status;
  spc_pkg::spc_cmd_e wcmd_dec;
  logic ctrl_wr;
  logic status_wr;
  logic store_go;
  logic load_go;
  logic [7:0] lf_byte;
  logic lf_hit;

  // ----------------------------------------------------------------------
  // access and instruction strobes
  // ----------------------------------------------------------------------
  assign acc = psel & penable & s.apb.pready;
  assign setup = psel & penable & ~s.apb.pready;
  assign wcmd = pwdata[`SPC_CTRL_CMD_W-1:0];
  assign page = pointer[15:`SPC_PAGE_LSB];
  // register writes take effect at the edge that ends the access phase
  assign ctrl_wr = acc & pwrite & (paddr[`SPC_OFS_W-1:0] == `SPC_OFS_CTRL);
  assign status_wr = acc & pwrite &
                     (paddr[`SPC_OFS_W-1:0] == `SPC_OFS_STATUS);
  // a running page op owns arm, so neither instruction is taken then
  assign store_go = program_store_instruction & s.arm & ~s.op_busy;
  assign load_go = program_load_instruction & s.arm & ~s.op_busy &
                   (s.cmd == spc_pkg::spc_cmd_lock) &
                   (s.cnt < `SPC_LOAD_WIN) &
                   ~eeprom_program_busy;

  // each of the two lock sets guards one section; both set guards all,
  // none set leaves the whole flash writable
  assign protected_page = (page >= BOOT_START_PAGE) ?
                          s.lock[`SPC_LOCK_BOOT_WP] :
                          s.lock[`SPC_LOCK_APP_WP];

  always_comb begin
    rd_ctrl = 8'h00;
    rd_ctrl[`SPC_CTRL_ARM] = s.arm;
    rd_ctrl[`SPC_CTRL_ERASE] = s.cmd == spc_pkg::spc_cmd_erase;
    rd_ctrl[`SPC_CTRL_WRITE] = s.cmd == spc_pkg::spc_cmd_write;
    rd_ctrl[`SPC_CTRL_LFSEL] = s.cmd == spc_pkg::spc_cmd_lock;
    rd_ctrl[`SPC_CTRL_RWW] = s.cmd == spc_pkg::spc_cmd_rww;
    rd_ctrl[`SPC_CTRL_BUSY] = s.op_busy;
  end

  // refused is sticky until software writes one to it
  always_comb begin
    rd_status = 8'h00;
    rd_status[`SPC_STAT_OP_BUSY] = s.op_busy;
    rd_status[`SPC_STAT_EE_BUSY] = eeprom_program_busy;
    rd_status[`SPC_STAT_REFUSED] = s.refused;
  end

  // ----------------------------------------------------------------------
  // decode of control writes and of the load pointer
  // ----------------------------------------------------------------------
  // any low pattern but the legal five decodes to no command, so such a
  // write can neither arm nor stretch a window that is already open
  always_comb begin
    unique case (wcmd)
      `SPC_PAT_FILL: wcmd_dec = spc_pkg::spc_cmd_fill;
      `SPC_PAT_ERASE: wcmd_dec = spc_pkg::spc_cmd_erase;
      `SPC_PAT_WRITE: wcmd_dec = spc_pkg::spc_cmd_write;
      `SPC_PAT_LFSEL: wcmd_dec = spc_pkg::spc_cmd_lock;
      `SPC_PAT_RWW: wcmd_dec = spc_pkg::spc_cmd_rww;
      default: wcmd_dec = spc_pkg::spc_cmd_none;
    endcase
  end

  // lock or fuse byte picked by the pointer; other pointers give none
  always_comb begin
    lf_hit = 1'b1;
    lf_byte = 8'h00;
    unique case (pointer)
      `SPC_PTR_FUSE_LOW: lf_byte = fuse_low_byte;
      `SPC_PTR_LOCK: lf_byte = s.lock;
      `SPC_PTR_EXT_FUSE: lf_byte = extended_fuse_byte;
      `SPC_PTR_FUSE_HIGH: lf_byte = fuse_high_byte;
      default: lf_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ld_valid = 1'b0;
    next_s.store_done = 1'b0;
    next_s.rww_pulse = 1'b0;
    next_s.flash.req = 1'b0;
    next_s.buf_wr.we = 1'b0;

    // apb: one wait state, answer registered with pready
    next_s.apb.pready = setup;
    if (setup) begin
      next_s.apb.pslverr = 1'b0;
      next_s.apb.prdata = 32'h0000_0000;
      unique case (paddr[`SPC_OFS_W-1:0])
        `SPC_OFS_CTRL: next_s.apb.prdata[7:0] = rd_ctrl;
        `SPC_OFS_STATUS: next_s.apb.prdata[7:0] = rd_status;
        `SPC_OFS_LOCK: next_s.apb.prdata[7:0] = s.lock;
        `SPC_OFS_FUSE: next_s.apb.prdata[23:0] =
          {extended_fuse_byte, fuse_high_byte, fuse_low_byte};
        default: next_s.apb.pslverr = 1'b1;
      endcase
    end

    // window count; a running page op freezes it and keeps arm high
    if (s.arm && !s.op_busy) begin
      if (s.cnt == `SPC_STORE_WIN - 3'h1) begin
        next_s.arm = 1'b0;
        next_s.cmd = spc_pkg::spc_cmd_none;
        next_s.cnt = 3'h0;
      end else begin
        next_s.cnt = s.cnt + 3'h1;
      end
    end

    // end of page erase or page write
    if (s.op_busy && flash_done) begin
      next_s.op_busy = 1'b0;
      next_s.arm = 1'b0;
      next_s.cmd = spc_pkg::spc_cmd_none;
      next_s.cnt = 3'h0;
      next_s.store_done = 1'b1;
    end

    // refused flag: software clears by writing one, a new event wins
    if (status_wr && pwdata[`SPC_STAT_REFUSED]) begin
      next_s.refused = 1'b0;
    end

    // lock bits: chip erase and reset are the only ways back to zero
    if (chip_erase) begin
      next_s.lock = `SPC_LOCK_RESET;
    end
    if (ext_lock_set) begin
      next_s.lock = next_s.lock | ext_lock_data;
    end

    // store instruction; the general lock mode bits are never consulted
    if (store_go) begin
      next_s.arm = 1'b0;
      next_s.cmd = spc_pkg::spc_cmd_none;
      next_s.cnt = 3'h0;
      if (eeprom_program_busy) begin
        next_s.refused = 1'b1;
      end else begin
        unique case (s.cmd)
          spc_pkg::spc_cmd_fill: begin
            next_s.buf_wr.we = 1'b1;
            next_s.buf_wr.addr = pointer[`SPC_BUF_AW:1];
            next_s.buf_wr.data = data_word_pair;
            next_s.store_done = 1'b1;
          end
          spc_pkg::spc_cmd_erase, spc_pkg::spc_cmd_write: begin
            if (protected_page) begin
              next_s.refused = 1'b1;
            end else begin
              next_s.flash.req = 1'b1;
              next_s.flash.is_write = s.cmd == spc_pkg::spc_cmd_write;
              next_s.flash.page = page;
              next_s.op_busy = 1'b1;
              next_s.arm = 1'b1;
              next_s.cmd = s.cmd;
              next_s.cnt = s.cnt;
            end
          end
          spc_pkg::spc_cmd_lock: begin
            next_s.lock = next_s.lock |
              (data_word_pair[7:0] & `SPC_LOCK_SW_MASK);
            next_s.store_done = 1'b1;
          end
          spc_pkg::spc_cmd_rww: begin
            next_s.rww_pulse = 1'b1;
            next_s.store_done = 1'b1;
          end
          default: begin
            next_s.store_done = 1'b0;
          end
        endcase
      end
    end

    // load instruction: lock and fuse bytes only inside the short window
    if (load_go && lf_hit) begin
      next_s.ld_valid = 1'b1;
      next_s.ld_data = lf_byte;
      next_s.arm = 1'b0;
      next_s.cmd = spc_pkg::spc_cmd_none;
      next_s.cnt = 3'h0;
    end

    // arming write; refused while the eeprom is being written
    // a write while a page op runs is dropped: arm belongs to that op
    if (ctrl_wr && !s.op_busy) begin
      if (eeprom_program_busy) begin
        next_s.refused = 1'b1;
      end else if (wcmd_dec != spc_pkg::spc_cmd_none) begin
        next_s.cnt = 3'h0;
        next_s.arm = 1'b1;
        next_s.cmd = wcmd_dec;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.arm <= 1'b0;
      s.cmd <= spc_pkg::spc_cmd_none;
      s.cnt <= 3'h0;
      s.op_busy <= 1'b0;
      s.refused <= 1'b0;
      s.lock <= `SPC_LOCK_RESET;
      s.apb <= '0;
      s.ld_valid <= 1'b0;
      s.ld_data <= 8'h00;
      s.store_done <= 1'b0;
      s.rww_pulse <= 1'b0;
      s.flash <= '0;
      s.buf_wr <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------------
  spc_page_buf #(
    .DW(`SPC_WORD_W),
    .AW(`SPC_BUF_AW)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .we(s.buf_wr.we),
    .waddr(s.buf_wr.addr),
    .wdata(s.buf_wr.data),
    .raddr(flash_buf_addr),
    .rdata(flash_buf_data)
  );

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign prdata = s.apb.prdata;
  assign pready = s.apb.pready;
  assign pslverr = s.apb.pslverr;
  assign store_done = s.store_done;
  assign lock_fuse_load_valid = s.ld_valid;
  assign lock_fuse_load_data = s.ld_data;
  assign flash_req = s.flash.req;
  assign flash_is_write = s.flash.is_write;
  assign flash_page = s.flash.page;
  assign rww_section_reenable = s.rww_pulse;

endmodule : spc_top

// >>> test/spc_top_checker.sv
// concurrent checks on the ports of the self-programming controller
`timescale 1ns/1ns
module spc_top_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // processor core side
  input wire logic program_store_instruction,
  input wire logic program_load_instruction,
  input wire logic [15:0] pointer,
  input wire logic store_done,
  input wire logic lock_fuse_load_valid,
  input wire logic [7:0] lock_fuse_load_data,
  // eeprom, fuses and flash
  input wire logic eeprom_program_busy,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] extended_fuse_byte,
  input wire logic flash_done,
  input wire logic flash_req,
  input wire logic [8:0] flash_page,
  input wire logic rww_section_reenable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_load_cause: assert property (
    lock_fuse_load_valid |-> $past(program_load_instruction)
      && $past(pointer) < 16'h0004
  ) else $error("lock or fuse answer without a load");
  chk_ee_read: assert property (
    lock_fuse_load_valid |-> !$past(eeprom_program_busy)
  ) else $error("fuse read during eeprom write");
  chk_ee_flash: assert property (
    flash_req |-> !$past(eeprom_program_busy)
  ) else $error("flash op started during eeprom write");
  chk_fuse_low: assert property (
    lock_fuse_load_valid && $past(pointer) == 16'h0000
      |-> lock_fuse_load_data == fuse_low_byte
  ) else $error("fuse low byte wrong");
  chk_fuse_high: assert property (
    lock_fuse_load_valid && $past(pointer) == 16'h0003
      |-> lock_fuse_load_data == fuse_high_byte
  ) else $error("fuse high byte wrong");
  chk_fuse_ext: assert property (
    lock_fuse_load_valid && $past(pointer) == 16'h0002
      |-> lock_fuse_load_data == extended_fuse_byte
  ) else $error("extended fuse byte wrong");
  chk_page_sel: assert property (
    flash_req |-> $past(program_store_instruction)
      && {7'h00, flash_page} == ($past(pointer) >> 7)
  ) else $error("flash op page or cause wrong");
  chk_done_cause: assert property (
    store_done |-> $past(program_store_instruction) || $past(flash_done)
  ) else $error("store done without cause");
  chk_rww_pulse: assert property (
    rww_section_reenable |-> $past(program_store_instruction)
      ##1 !rww_section_reenable
  ) else $error("section re-enable pulse wrong");
  chk_reset_quiet: assert property (
    $rose(presetn) |-> !store_done && !flash_req && !lock_fuse_load_valid
  ) else $error("output active right after reset");
  cov_fill: cover property (store_done && $past(program_store_instruction));
  cov_lock_read: cover property (lock_fuse_load_valid);
  cov_page_op: cover property (flash_req ##[1:20] flash_done);
endmodule : spc_top_checker

// >>> test/spc_core_model.sv
// processor core model: issues store and load instructions
`timescale 1ns/1ns
module spc_core_model (
  // clock
  input wire logic pclk,
  // instructions towards the controller
  output logic program_store_instruction,
  output logic program_load_instruction,
  output logic [15:0] pointer,
  output logic [15:0] data_word_pair,
  // answers from the controller
  input wire logic store_done,
  input wire logic lock_fuse_load_valid,
  input wire logic [7:0] lock_fuse_load_data
);
  initial begin
    program_store_instruction = 1'b0;
    program_load_instruction = 1'b0;
    pointer = 16'hFFFF;
    data_word_pair = 16'hFFFF;
  end
  // dly idle cycles first; operands hold for the instruction cycle only,
  // then show their inverse so a stale value can never pass as fresh
  task automatic store(input int dly, input logic [15:0] p,
                       input logic [15:0] d, output logic done);
    repeat (dly) @(posedge pclk);
    pointer <= p;
    data_word_pair <= d;
    program_store_instruction <= 1'b1;
    @(posedge pclk);
    program_store_instruction <= 1'b0;
    pointer <= ~p;
    data_word_pair <= ~d;
    @(posedge pclk);
    done = store_done;
  endtask : store
  // a lock or fuse read needs the load within three cycles of arming
  task automatic load(input int dly, input logic [15:0] p,
                      output logic v, output logic [7:0] d);
    repeat (dly) @(posedge pclk);
    pointer <= p;
    program_load_instruction <= 1'b1;
    @(posedge pclk);
    program_load_instruction <= 1'b0;
    pointer <= ~p;
    @(posedge pclk);
    v = lock_fuse_load_valid;
    d = lock_fuse_load_data;
  endtask : load
endmodule : spc_core_model

// >>> test/spc_top_tb.sv
// testbench of the self-programming controller
`timescale 1ns/1ns
module spc_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ok;
  logic program_store_instruction, program_load_instruction;
  logic [15:0] pointer, data_word_pair, flash_buf_data;
  logic store_done, lock_fuse_load_valid, flash_req, flash_is_write;
  logic [7:0] lock_fuse_load_data, d8;
  logic rww_section_reenable;
  logic [8:0] flash_page;
  logic eeprom_program_busy = 1'b0, chip_erase = 1'b0;
  logic ext_lock_set = 1'b0, flash_done = 1'b0;
  logic [7:0] fuse_low_byte = 8'h62, fuse_high_byte = 8'hDF;
  logic [7:0] extended_fuse_byte = 8'hF9, ext_lock_data = 8'h13;
  logic [5:0] flash_buf_addr = 6'h00;
  logic [7:0] exp_lf [4] = '{8'h62, 8'h13, 8'hF9, 8'hDF};
  logic [7:0] bad [3] = '{8'h07, 8'h1F, 8'h02};
  logic [7:0] ops [2] = '{8'h03, 8'h05};
  int n_mismatch = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  spc_top u_spc_top (.*);
  spc_core_model u_spc_core_model (.*);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_val(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string nm, input logic e, g);
    chk_val(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  // one apb transfer; one idle edge after it keeps drivers single-assigned
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : apb
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk_val("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h08, 32'h0, rd);
    chk_val("lock reset", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk_bit("eeprom idle", 1'b0, rd[1]);
    apb(1'b0, 8'h10, 32'h0, rd);
    chk_bit("unmapped err", 1'b1, err);
    apb(1'b1, 8'h00, 32'h01, rd);
    u_spc_core_model.store(0, 16'h0043, 16'hA55A, ok);
    chk_bit("fill done", 1'b1, ok);
    flash_buf_addr <= 6'h21;
    repeat (2) @(posedge pclk);
    chk_val("buffer word", 32'hA55A, {16'h0, flash_buf_data});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 32'h01, rd);
      u_spc_core_model.store(i, 16'h0002, 16'h1234, ok);
      chk_bit("store window", i < 3, ok);
    end
    apb(1'b0, 8'h00, 32'h0, rd);
    chk_bit("arm expired", 1'b0, rd[0]);
    // general lock mode bits set too: loads and stores must ignore them
    ext_lock_set <= 1'b1;
    @(posedge pclk);
    ext_lock_set <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 8'h00, 32'h09, rd);
      u_spc_core_model.load(0, 16'(p), ok, d8);
      chk_bit("lf valid", 1'b1, ok);
      chk_val("lf data", {24'h0, exp_lf[p]}, {24'h0, d8});
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, 32'h09, rd);
      u_spc_core_model.load(i, 16'h0000, ok, d8);
      chk_bit("load window", i < 2, ok);
    end
    u_spc_core_model.load(0, 16'h0001, ok, d8);
    chk_bit("plain load", 1'b0, ok);
    apb(1'b1, 8'h00, 32'h01, rd);
    apb(1'b1, 8'h00, 32'h07, rd);
    u_spc_core_model.store(0, 16'h0002, 16'h0000, ok);
    chk_bit("bad keeps window", 1'b0, ok);
    foreach (bad[k]) begin
      apb(1'b1, 8'h00, {24'h0, bad[k]}, rd);
      apb(1'b0, 8'h00, 32'h0, rd);
      chk_val("bad pattern", 32'h0, {27'h0, rd[4:0]});
    end
    foreach (ops[k]) begin
      apb(1'b1, 8'h00, {24'h0, ops[k]}, rd);
      u_spc_core_model.store(0, 16'h3880, 16'h0000, ok);
      chk_bit("op early done", 1'b0, ok);
      chk_bit("op request", 1'b1, flash_req);
      chk_val("op page", 32'h071, {23'h0, flash_page});
      chk_bit("op kind", k == 1, flash_is_write);
      apb(1'b0, 8'h00, 32'h0, rd);
      chk_bit("arm held", 1'b1, rd[0]);
      flash_done <= 1'b1;
      @(posedge pclk);
      flash_done <= 1'b0;
      @(posedge pclk);
      chk_bit("op done", 1'b1, store_done);
      apb(1'b0, 8'h00, 32'h0, rd);
      chk_bit("arm after op", 1'b0, rd[0]);
    end
    apb(1'b1, 8'h00, 32'h03, rd);
    u_spc_core_model.store(0, 16'hE000, 16'h0000, ok);
    chk_bit("boot locked", 1'b0, flash_req);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk_bit("refused flag", 1'b1, rd[2]);
    apb(1'b1, 8'h04, 32'h04, rd);
    apb(1'b1, 8'h00, 32'h11, rd);
    u_spc_core_model.store(0, 16'h0000, 16'h0000, ok);
    chk_bit("reenable", 1'b1, rww_section_reenable);
    apb(1'b1, 8'h00, 32'h09, rd);
    u_spc_core_model.store(0, 16'h0000, 16'h00FF, ok);
    apb(1'b0, 8'h08, 32'h0, rd);
    chk_val("lock by store", 32'h3F, rd);
    apb(1'b1, 8'h00, 32'h03, rd);
    u_spc_core_model.store(0, 16'h3880, 16'h0000, ok);
    chk_bit("app locked", 1'b0, flash_req);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    apb(1'b0, 8'h08, 32'h0, rd);
    chk_val("lock erased", 32'h0, rd);
    eeprom_program_busy <= 1'b1;
    apb(1'b1, 8'h00, 32'h01, rd);
    u_spc_core_model.store(0, 16'h0002, 16'h5555, ok);
    chk_bit("ee blocks store", 1'b0, ok);
    apb(1'b1, 8'h00, 32'h09, rd);
    u_spc_core_model.load(0, 16'h0000, ok, d8);
    chk_bit("ee blocks read", 1'b0, ok);
    eeprom_program_busy <= 1'b0;
    apb(1'b1, 8'h00, 32'h01, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk_val("ctrl after reset", 32'h0, rd);
    report_and_stop();
  end
endmodule : spc_top_tb
bind spc_top spc_top_checker u_spc_top_checker (.*);
